// ==== core/dpacq_core.sv ====
// acquisition trigger decision, feedback time shift, tuning word clamp
// assumes apb master per amba rules; sequencer and history are outside
`timescale 1ns/1ps
module dpacq_core #(
    parameter int TW_W = dpacq_pkg::TW_W
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [17:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire dpacq_pkg::dpacq_acq_req_t acq_req_in,
    input wire dpacq_pkg::dpacq_seq_stat_t seq_stat_in,
    output logic fast_acq_out,
    output logic normal_acq_out,
    input wire logic signed [dpacq_pkg::OFS_W-1:0] skew_ofs_in,
    input wire logic signed [dpacq_pkg::OFS_W-1:0] comp_ofs_in,
    output logic signed [dpacq_pkg::OFS_W+1:0] fb_sum_out,
    input wire dpacq_pkg::dpacq_tw_src_t tw_src_in,
    input wire logic [TW_W-1:0] tw_in,
    output logic [TW_W-1:0] tw_out,
    output logic clamp_active_out
);
    localparam int OW = dpacq_pkg::OFS_W;
    localparam int LW = dpacq_pkg::LIM_W;

    logic [LW-1:0] clamp_limit;
    logic [OW-1:0] time_shift;
    logic [7:0] mode_ctrl;
    logic [3:0] trig_en;
    logic done;
    logic [1:0] events;
    logic clamping;
    logic [15:0] idx;
    logic wr;
    logic rd;
    logic mapped;

    function automatic logic is_mapped(input logic [15:0] i);
        case (i)
            dpacq_pkg::IDX_CLAMP_LIMIT, dpacq_pkg::IDX_TIME_SHIFT_LO,
            dpacq_pkg::IDX_TIME_SHIFT_HI, dpacq_pkg::IDX_EVENT_CLEAR,
            dpacq_pkg::IDX_MODE_CTRL, dpacq_pkg::IDX_TRIG_EN,
            dpacq_pkg::IDX_DONE_CLEAR, dpacq_pkg::IDX_LATCHED,
            dpacq_pkg::IDX_LIVE: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    assign idx = paddr_in[17:2];
    assign mapped = is_mapped(idx);
    assign wr = psel_in && penable_in && pwrite_in && pready_out;
    assign rd = psel_in && !penable_in && !pwrite_in;

    // no wait state: ready rises in the first access cycle
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !mapped;
        end
    end

    ready_setup_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        psel_in && !penable_in |=> pready_out)
        else $error("setup phase not answered");
    ready_pulse_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        pready_out |=> !pready_out)
        else $error("ready held past one cycle");
    err_unmapped_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        psel_in && !penable_in && !mapped |=> pslverr_out)
        else $error("unmapped index not refused");
    err_with_ready_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        pslverr_out |-> pready_out)
        else $error("error without ready");

    // software-written configuration
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            clamp_limit <= dpacq_pkg::LIMIT_RESET;
            time_shift <= '0;
            mode_ctrl <= 8'h00;
            trig_en <= 4'h0;
        end else if (wr && mapped) begin
            case (idx)
                dpacq_pkg::IDX_CLAMP_LIMIT: clamp_limit <= pwdata_in[LW-1:0];
                dpacq_pkg::IDX_TIME_SHIFT_LO: time_shift[31:0] <= pwdata_in;
                dpacq_pkg::IDX_TIME_SHIFT_HI:
                    time_shift[OW-1:32] <= pwdata_in[OW-33:0];
                dpacq_pkg::IDX_MODE_CTRL: mode_ctrl <= pwdata_in[7:0];
                dpacq_pkg::IDX_TRIG_EN: trig_en <= pwdata_in[3:0];
                default: ;
            endcase
        end
    end

    trig_write_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        wr && idx == dpacq_pkg::IDX_TRIG_EN
        |=> trig_en == $past(pwdata_in[3:0]))
        else $error("trigger enables not stored");
    limit_write_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        wr && idx == dpacq_pkg::IDX_CLAMP_LIMIT
        |=> clamp_limit == $past(pwdata_in[LW-1:0]))
        else $error("clamp limit not stored");

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0;
        end else if (rd) begin
            case (idx)
                dpacq_pkg::IDX_CLAMP_LIMIT:
                    prdata_out <= {{(32-LW){1'b0}}, clamp_limit};
                dpacq_pkg::IDX_TIME_SHIFT_LO: prdata_out <= time_shift[31:0];
                dpacq_pkg::IDX_TIME_SHIFT_HI:
                    prdata_out <= {{(64-OW){1'b0}}, time_shift[OW-1:32]};
                dpacq_pkg::IDX_MODE_CTRL: prdata_out <= {24'h0, mode_ctrl};
                dpacq_pkg::IDX_TRIG_EN: prdata_out <= {28'h0, trig_en};
                dpacq_pkg::IDX_LATCHED: prdata_out <= {24'h0, events, 6'h0};
                dpacq_pkg::IDX_LIVE: prdata_out <= {26'h0, done,
                    seq_stat_in.running, 2'h0, clamping, 1'b0};
                default: prdata_out <= 32'h0;
            endcase
        end
    end

    live_clamp_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        rd && idx == dpacq_pkg::IDX_LIVE
        |=> prdata_out[1] == $past(clamp_active_out))
        else $error("live clamp bit wrong");
    live_done_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        rd && idx == dpacq_pkg::IDX_LIVE
        |=> prdata_out[5] == $past(done)
        && prdata_out[4] == $past(seq_stat_in.running))
        else $error("live sequencer bits wrong");

    // trigger decision, one cycle after the acquisition start
    logic cond_any;
    assign cond_any =
        (trig_en[0] && acq_req_in.origin == dpacq_pkg::DPACQ_FROM_FREERUN)
        || (trig_en[1] && acq_req_in.origin == dpacq_pkg::DPACQ_FROM_HOLDOVER)
        || (trig_en[2] && !done)
        || (trig_en[3] && acq_req_in.outputs_idle);

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            fast_acq_out <= 1'b0;
            normal_acq_out <= 1'b0;
        end else begin
            fast_acq_out <= acq_req_in.start
                && (trig_en == 4'h0 || cond_any);
            normal_acq_out <= acq_req_in.start
                && trig_en != 4'h0 && !cond_any;
        end
    end

    free_fast_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        acq_req_in.start && trig_en == 4'h0 |=> fast_acq_out)
        else $error("unrestricted acquisition not fast");
    normal_acq_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        acq_req_in.start && trig_en != 4'h0 && !cond_any
        |=> normal_acq_out && !fast_acq_out)
        else $error("restricted acquisition not normal");
    first_acq_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        acq_req_in.start && trig_en[2] && !done |=> fast_acq_out)
        else $error("first acquisition not fast");
    freerun_fast_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        acq_req_in.start && trig_en[0]
        && acq_req_in.origin == dpacq_pkg::DPACQ_FROM_FREERUN
        |=> fast_acq_out)
        else $error("entry from freerun not fast");
    holdover_fast_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        acq_req_in.start && trig_en[1]
        && acq_req_in.origin == dpacq_pkg::DPACQ_FROM_HOLDOVER
        |=> fast_acq_out)
        else $error("entry from holdover not fast");
    idle_fast_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        acq_req_in.start && trig_en[3] && acq_req_in.outputs_idle
        |=> fast_acq_out)
        else $error("idle outputs not fast");
    any_cond_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        acq_req_in.start && trig_en != 4'h0 && cond_any
        |=> fast_acq_out && !normal_acq_out)
        else $error("met condition not fast");
    one_kind_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !(fast_acq_out && normal_acq_out))
        else $error("fast and normal together");
    no_start_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !acq_req_in.start |=> !fast_acq_out && !normal_acq_out)
        else $error("acquisition without start");

    // done: set by completion (not timeout), set beats software clear
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            done <= 1'b0;
        end else if (seq_stat_in.finished && !seq_stat_in.timed_out) begin
            done <= 1'b1;
        end else if (wr && idx == dpacq_pkg::IDX_DONE_CLEAR
                     && pwdata_in[dpacq_pkg::BIT_DONE_CLEAR]) begin
            done <= 1'b0;
        end
    end

    timeout_done_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !done && !(seq_stat_in.finished && !seq_stat_in.timed_out)
        |=> !done)
        else $error("done set without completion");
    done_set_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        seq_stat_in.finished && !seq_stat_in.timed_out |=> done)
        else $error("completion not recorded");
    done_clear_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        wr && idx == dpacq_pkg::IDX_DONE_CLEAR
        && pwdata_in[dpacq_pkg::BIT_DONE_CLEAR]
        && !(seq_stat_in.finished && !seq_stat_in.timed_out)
        |=> !done)
        else $error("done not cleared");

    // feedback summing node; positive shift delays output edges
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            fb_sum_out <= '0;
        end else begin
            fb_sum_out <= (OW+2)'($signed(time_shift))
                + (OW+2)'(skew_ofs_in) + (OW+2)'(comp_ofs_in);
        end
    end

    shift_delay_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !time_shift[OW-1] && time_shift != '0
        && skew_ofs_in == '0 && comp_ofs_in == '0
        |=> fb_sum_out > 0)
        else $error("positive shift not a delay");
    shift_advance_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        time_shift[OW-1] && skew_ofs_in == '0 && comp_ofs_in == '0
        |=> fb_sum_out < 0)
        else $error("negative shift not an advance");
    skew_join_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        time_shift == '0 && comp_ofs_in == '0
        |=> fb_sum_out == $past(skew_ofs_in))
        else $error("skew offset not summed");

    // clamp centre selection and saturation
    logic [TW_W-1:0] centre;
    logic [TW_W:0] span;
    logic [TW_W+1:0] hi_b;
    logic signed [TW_W+1:0] lo_b;
    logic above;
    logic below;
    always_comb begin
        if (mode_ctrl[dpacq_pkg::BIT_FORCE_OPEN]) begin
            centre = tw_src_in.freerun_word;
        end else if (tw_src_in.history_enabled
                     && tw_src_in.history_valid) begin
            centre = tw_src_in.history_word;
        end else begin
            centre = tw_src_in.filter_word;
        end
    end
    // limit lsb is fs/2^36, i.e. tuning word lsb scaled by 2^LIM_SHIFT
    assign span = (TW_W+1)'({clamp_limit, {dpacq_pkg::LIM_SHIFT{1'b0}}});
    assign hi_b = {1'b0, centre} + {1'b0, span};
    assign lo_b = $signed({2'b00, centre}) - $signed({1'b0, span});
    assign above = {2'b00, tw_in} > hi_b;
    assign below = $signed({2'b00, tw_in}) < lo_b;
    assign clamping = clamp_active_out;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tw_out <= '0;
            clamp_active_out <= 1'b0;
        end else begin
            if (above) begin
                tw_out <= hi_b[TW_W] ? '1 : hi_b[TW_W-1:0];
            end else if (below) begin
                tw_out <= lo_b[TW_W+1] ? '0 : lo_b[TW_W-1:0];
            end else begin
                tw_out <= tw_in;
            end
            clamp_active_out <= above || below;
        end
    end

    clamp_bound_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        above |=> clamp_active_out && tw_out != $past(tw_in))
        else $error("word above bound passed through");
    clamp_below_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        below |=> clamp_active_out && tw_out > $past(tw_in))
        else $error("word below bound passed through");
    clamp_pass_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !above && !below
        |=> !clamp_active_out && tw_out == $past(tw_in))
        else $error("word inside window altered");
    force_centre_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        mode_ctrl[0] && tw_in == tw_src_in.freerun_word |=> !clamp_active_out)
        else $error("freerun centre not used");
    hist_centre_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !mode_ctrl[dpacq_pkg::BIT_FORCE_OPEN] && tw_src_in.history_enabled
        && tw_src_in.history_valid && tw_in == tw_src_in.history_word
        |=> !clamp_active_out)
        else $error("history centre not used");
    filt_centre_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !mode_ctrl[dpacq_pkg::BIT_FORCE_OPEN] && !tw_src_in.history_valid
        && tw_in == tw_src_in.filter_word |=> !clamp_active_out)
        else $error("filter centre not used");

    // latched transitions; set wins over clear
    logic prev_clamp;
    logic clr_on;
    logic clr_off;
    assign clr_on = wr && idx == dpacq_pkg::IDX_EVENT_CLEAR
        && pwdata_in[dpacq_pkg::BIT_CLAMP_ON];
    assign clr_off = wr && idx == dpacq_pkg::IDX_EVENT_CLEAR
        && pwdata_in[dpacq_pkg::BIT_CLAMP_OFF];
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            prev_clamp <= 1'b0;
            events <= 2'b00;
        end else begin
            prev_clamp <= clamping;
            events[0] <= (clamping && !prev_clamp) || (events[0] && !clr_on);
            events[1] <= (!clamping && prev_clamp)
                || (events[1] && !clr_off);
        end
    end

    clamp_rise_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        clamping && !$past(clamping) |=> events[0])
        else $error("clamp activation not latched");
    clamp_fall_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !clamping && $past(clamping) |=> events[1])
        else $error("clamp release not latched");
    event_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        events[0] && !clr_on |=> events[0])
        else $error("activated event lost without clear");
    off_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        events[1] && !clr_off |=> events[1])
        else $error("released event lost without clear");
    on_clear_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        events[0] && clr_on && !(clamping && !$past(clamping))
        |=> !events[0])
        else $error("activated event not cleared");
    no_false_on_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !events[0] && !(clamping && !$past(clamping)) |=> !events[0])
        else $error("activated event without transition");
endmodule

// ==== common/dpacq_pkg.sv ====
// constants and carrier types for the loop acquisition/offset/clamp block
// assumes one loop channel, registers reached over apb at word index * 4
// Contract
// - control low nibble: freerun, holdover, first, no-output enables
// - all enables zero: every acquisition is a fast one
// - any enable set: fast if any enabled condition holds (or)
// - freerun enable: fast on closed-loop entry from freerun
// - holdover enable: fast on closed-loop entry from holdover
// - first enable: fast only while done status is zero
// - writing one to self-clearing bit clears done, re-arming first trigger
// - no-output enable: fast when no driven output toggles
// - restricted and no condition holds: normal acquisition
// - add 40-bit signed picosecond offset at feedback summing node
// - positive offset delays output edges, negative advances them
// - summing node also takes profile skew and delay compensation offsets
// - clamp always active; 24-bit limit resets to all ones
// - bound frequency to centre plus or minus limit times fs over 2^36
// - force open loop set: centre is freerun tuning word
// - history off or not valid: centre is loop filter output
// - history on and valid: centre is averaged history word
// - live clamp-active status bit while limiting
// - latched activated event on not-limiting to limiting
// - latched deactivated event on limiting to not-limiting
// - latched events stay set until cleared via event clear bits
// - sequencer active bit while running; done on completion, not timeout
package dpacq_pkg;
    localparam int TW_W = 48;
    localparam int OFS_W = 40;
    localparam int LIM_W = 24;
    localparam int LIM_SHIFT = 12;
    localparam logic [15:0] IDX_CLAMP_LIMIT = 16'h1006;
    localparam logic [15:0] IDX_TIME_SHIFT_LO = 16'h1015;
    localparam logic [15:0] IDX_TIME_SHIFT_HI = 16'h1016;
    localparam logic [15:0] IDX_EVENT_CLEAR = 16'h200B;
    localparam logic [15:0] IDX_MODE_CTRL = 16'h2105;
    localparam logic [15:0] IDX_TRIG_EN = 16'h2106;
    localparam logic [15:0] IDX_DONE_CLEAR = 16'h2107;
    localparam logic [15:0] IDX_LATCHED = 16'h3010;
    localparam logic [15:0] IDX_LIVE = 16'h3102;
    localparam logic [LIM_W-1:0] LIMIT_RESET = 24'hFFFFFF;
    localparam int BIT_FORCE_OPEN = 0;
    localparam int BIT_DONE_CLEAR = 3;
    localparam int BIT_CLAMP_ON = 6;
    localparam int BIT_CLAMP_OFF = 7;
    localparam int BIT_LIVE_CLAMP = 1;
    localparam int BIT_LIVE_ACTIVE = 4;
    localparam int BIT_LIVE_DONE = 5;
    typedef enum logic [1:0] {
        DPACQ_FROM_FREERUN,
        DPACQ_FROM_HOLDOVER,
        DPACQ_FROM_OTHER
    } dpacq_origin_t;
    typedef struct packed {
        logic start;
        dpacq_origin_t origin;
        logic outputs_idle;
    } dpacq_acq_req_t;
    typedef struct packed {
        logic running;
        logic finished;
        logic timed_out;
    } dpacq_seq_stat_t;
    typedef struct packed {
        logic [TW_W-1:0] freerun_word;
        logic [TW_W-1:0] filter_word;
        logic [TW_W-1:0] history_word;
        logic history_enabled;
        logic history_valid;
    } dpacq_tw_src_t;
endpackage

// ==== testbench/test_dpacq_core.sv ====
// bench for the acquisition trigger, feedback time shift and tuning clamp
// assumes dpacq_core with apb at byte address index*4, one 25 MHz clock
`timescale 1ns/1ps
module test_dpacq_core;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, bus_err;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    dpacq_pkg::dpacq_acq_req_t acq = '0;
    dpacq_pkg::dpacq_seq_stat_t seq = '0;
    dpacq_pkg::dpacq_tw_src_t src = '0;
    logic signed [39:0] skew = 40'h0, comp = 40'h0;
    logic signed [41:0] fb;
    logic [47:0] tw = 48'h0, tw_o;
    logic fast, norm, clamp;
    int failures = 0, samples_checked = 0;
    localparam logic [47:0] CTR = 48'h000010000000;

    dpacq_core dut_u (.ref_clk_in(clk), .rst_in(rst), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .acq_req_in(acq), .seq_stat_in(seq),
        .fast_acq_out(fast), .normal_acq_out(norm), .skew_ofs_in(skew),
        .comp_ofs_in(comp), .fb_sum_out(fb), .tw_src_in(src), .tw_in(tw),
        .tw_out(tw_o), .clamp_active_out(clamp));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [47:0] got, exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] idx,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        bus_err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        chk(n < 20, 1'b1, "no ready");
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic acq_try(input dpacq_pkg::dpacq_origin_t o,
                           input logic idle, input logic exp);
        @(posedge clk);
        acq.start <= 1'b1;
        acq.origin <= o;
        acq.outputs_idle <= idle;
        @(posedge clk);
        acq.start <= 1'b0;
        #1;
        chk(fast, exp, "fast pulse");
        chk(norm, !exp, "normal pulse");
    endtask

    task automatic fin(input logic to);
        @(posedge clk);
        seq <= '{running: 1'b0, finished: 1'b1, timed_out: to};
        @(posedge clk);
        seq <= '0;
        tick(2);
    endtask

    task automatic tw_try(input logic [47:0] v, exp, input logic act);
        @(posedge clk);
        tw <= v;
        tick(3);
        chk(tw_o, exp, "clamped word");
        chk(clamp, act, "clamp level");
    endtask

    task automatic t_reset;
        bus(0, dpacq_pkg::IDX_CLAMP_LIMIT, 32'h0);
        chk(rd, 32'h00FFFFFF, "limit reset");
        bus(0, 16'h0777, 32'h0);
        chk({bus_err, rd}, 33'h100000000, "unmapped read");
        bus(1, 16'h0777, 32'hFFFFFFFF);
        chk(bus_err, 1'b1, "unmapped write");
        $display("test reset done");
    endtask

    task automatic t_trigger;
        acq_try(dpacq_pkg::DPACQ_FROM_OTHER, 0, 1);
        bus(1, dpacq_pkg::IDX_TRIG_EN, 32'h2);
        acq_try(dpacq_pkg::DPACQ_FROM_FREERUN, 0, 0);
        acq_try(dpacq_pkg::DPACQ_FROM_HOLDOVER, 0, 1);
        bus(1, dpacq_pkg::IDX_TRIG_EN, 32'h1);
        acq_try(dpacq_pkg::DPACQ_FROM_FREERUN, 0, 1);
        acq_try(dpacq_pkg::DPACQ_FROM_HOLDOVER, 0, 0);
        bus(1, dpacq_pkg::IDX_TRIG_EN, 32'h8);
        acq_try(dpacq_pkg::DPACQ_FROM_OTHER, 1, 1);
        acq_try(dpacq_pkg::DPACQ_FROM_OTHER, 0, 0);
        bus(1, dpacq_pkg::IDX_TRIG_EN, 32'h4);
        seq <= '{running: 1'b1, finished: 1'b0, timed_out: 1'b0};
        bus(0, dpacq_pkg::IDX_LIVE, 32'h0);
        chk(rd & 32'h30, 32'h10, "running status");
        fin(1);
        bus(0, dpacq_pkg::IDX_LIVE, 32'h0);
        chk(rd & 32'h30, 32'h00, "done after timeout");
        acq_try(dpacq_pkg::DPACQ_FROM_OTHER, 0, 1);
        fin(0);
        bus(0, dpacq_pkg::IDX_LIVE, 32'h0);
        chk(rd & 32'h20, 32'h20, "done set");
        acq_try(dpacq_pkg::DPACQ_FROM_OTHER, 0, 0);
        bus(1, dpacq_pkg::IDX_DONE_CLEAR, 32'h8);
        bus(0, dpacq_pkg::IDX_LIVE, 32'h0);
        chk(rd & 32'h20, 32'h00, "done cleared");
        acq_try(dpacq_pkg::DPACQ_FROM_OTHER, 0, 1);
        $display("test trigger done");
    endtask

    task automatic t_offset;
        @(posedge clk);
        skew <= 40'h00000003E8;
        comp <= 40'hFFFFFFFE0C;
        bus(1, dpacq_pkg::IDX_TIME_SHIFT_LO, 32'hFFFEDB08);
        bus(1, dpacq_pkg::IDX_TIME_SHIFT_HI, 32'h000000FF);
        tick(2);
        chk({{6{fb[41]}}, fb}, 48'hFFFFFFFEDCFC, "feedback sum");
        bus(0, dpacq_pkg::IDX_TIME_SHIFT_LO, 32'h0);
        chk(rd, 32'hFFFEDB08, "shift readback");
        bus(0, dpacq_pkg::IDX_TIME_SHIFT_HI, 32'h0);
        chk(rd, 32'h000000FF, "shift high readback");
        skew <= 40'h0;
        comp <= 40'h0;
        bus(1, dpacq_pkg::IDX_TIME_SHIFT_HI, 32'h0);
        bus(1, dpacq_pkg::IDX_TIME_SHIFT_LO, 32'h000003E8);
        tick(2);
        chk({{6{fb[41]}}, fb}, 48'h0000000003E8, "delay sign");
        $display("test offset done");
    endtask

    task automatic t_clamp;
        bus(1, dpacq_pkg::IDX_CLAMP_LIMIT, 32'h2);
        src.filter_word <= CTR;
        tw_try(CTR + 48'h5000, CTR + 48'h2000, 1);
        tw_try(CTR - 48'h3000, CTR - 48'h2000, 1);
        bus(0, dpacq_pkg::IDX_LIVE, 32'h0);
        chk(rd & 32'h2, 32'h2, "live clamp bit");
        bus(0, dpacq_pkg::IDX_LATCHED, 32'h0);
        chk(rd & 32'hC0, 32'h40, "activated event");
        tw_try(CTR + 48'h100, CTR + 48'h100, 0);
        bus(0, dpacq_pkg::IDX_LATCHED, 32'h0);
        chk(rd & 32'hC0, 32'hC0, "both events held");
        bus(1, dpacq_pkg::IDX_EVENT_CLEAR, 32'hC0);
        bus(0, dpacq_pkg::IDX_LATCHED, 32'h0);
        chk(rd & 32'hC0, 32'h00, "events cleared");
        src.freerun_word <= CTR + 48'h10000;
        bus(1, dpacq_pkg::IDX_MODE_CTRL, 32'h1);
        tw_try(CTR + 48'h100, CTR + 48'hE000, 1);
        bus(1, dpacq_pkg::IDX_MODE_CTRL, 32'h0);
        src.history_word <= CTR - 48'h10000;
        src.history_enabled <= 1'b1;
        src.history_valid <= 1'b1;
        tw_try(CTR, CTR - 48'hE000, 1);
        @(posedge clk);
        src.history_valid <= 1'b0;
        tw_try(CTR, CTR, 0);
        $display("test clamp done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_trigger();
        t_offset();
        t_clamp();
        conclude();
    end
endmodule
